// ==== tcoc_pkg.sv ====
// Package for the timer compare output control block: map, fields, modes, carriers
package tcoc_pkg;

    // Bus and counter widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 16;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL_A = 8'h80;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_B = 8'h81;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h84;

    // Field positions
    localparam int CTRL_A_MODE_A_LSB = 6;
    localparam int CTRL_A_MODE_B_LSB = 4;
    localparam int CTRL_A_WGM_LO_LSB = 0;
    localparam int CTRL_B_WGM_HI_LSB = 3;
    localparam int STAT_CMP_A_BIT    = 0;
    localparam int STAT_CMP_B_BIT    = 1;
    localparam int STAT_OVF_BIT      = 2;

    // Reset values
    localparam logic [DATA_W-1:0] CTRL_A_RST = 8'h00;
    localparam logic [DATA_W-1:0] CTRL_B_RST = 8'h00;
    localparam logic [CNT_W-1:0]  CMP_RST    = 16'h0000;

    // Counter landmarks
    localparam logic [CNT_W-1:0] CNT_BOTTOM = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX    = 16'hFFFF;

    // Compare output mode codes
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    // Waveform modes that allow the channel A toggle
    localparam logic [3:0] WGM_FAST_TOG_LO = 4'hE;
    localparam logic [3:0] WGM_FAST_TOG_HI = 4'hF;
    localparam logic [3:0] WGM_DUAL_TOG_LO = 4'h9;
    localparam logic [3:0] WGM_DUAL_TOG_HI = 4'hB;

    // Waveform class, one-hot
    typedef enum logic [4:0] {
        CLS_NONPWM = 5'h01,
        CLS_PHASE  = 5'h02,
        CLS_PFC    = 5'h04,
        CLS_FAST   = 5'h08,
        CLS_RSVD   = 5'h10
    } tcoc_class_e;

    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              we;
        logic              re;
    } tcoc_bus_s;

    // Counter state from the counter core
    typedef struct packed {
        logic [CNT_W-1:0] value;
        logic [CNT_W-1:0] top;
        logic             down;
    } tcoc_cnt_s;

    // Waveform mode code to class
    function automatic tcoc_class_e tcoc_class(input logic [3:0] wgm);
        tcoc_class_e c;
        c = CLS_RSVD;
        case (wgm)
            4'h0, 4'h4, 4'hC:               c = CLS_NONPWM; // R17
            4'h1, 4'h2, 4'h3, 4'hA, 4'hB:   c = CLS_PHASE;  // R17
            4'h8, 4'h9:                     c = CLS_PFC;    // R17
            4'h5, 4'h6, 4'h7, 4'hE, 4'hF:   c = CLS_FAST;   // R17
            default:                        c = CLS_RSVD;   // R17
        endcase
        return c;
    endfunction

endpackage

// ==== tcoc_top.sv ====
// Compare output mode logic for two channels of a 16-bit timer
// Functional notes
// R1 - Everything runs on the I/O clock; timer tick is only a clock enable.
// R2 - Phase and frequency correct PWM loads compare values at BOTTOM.
// R3 - Overflow flag set at BOTTOM with the same offset TOP-based modes use.
// R4 - Any nonzero channel output mode field overrides the pin's port function.
// R5 - Software must set the pin direction to output for the wave to show.
// R6 - Field 00 disconnects the channel in every waveform mode.
// R7 - Non-PWM field 01 toggles the output on each compare match.
// R8 - Non-PWM field 10 drives the output low on compare match.
// R9 - Non-PWM field 11 drives the output high on compare match.
// R10 - Fast PWM 01 toggles A only in modes 14/15; otherwise disconnected. Here the wave holds but the override stays set.
// R11 - Fast PWM 10: clear on match, set at BOTTOM.
// R12 - Fast PWM 11: set on match, clear at BOTTOM.
// R13 - Fast PWM compare equal TOP with upper bit set: match ignored, BOTTOM acts.
// R14 - Dual-slope 01 toggles A only in modes 9/11; otherwise disconnected. Here the wave holds but the override stays set.
// R15 - Dual-slope 10: clear on up-count match, set on down-count match.
// R16 - Dual-slope 11: set on up-count match, clear on down-count match.
// R17 - Mode code classes: non-PWM, phase, phase-frequency, fast, reserved.
// R18 - Low mode bits in control A join high bits in control B.
// R19 - Dual-slope compare at BOTTOM holds low, at TOP holds high; inverted opposite.
// R20 - Compare flag sets on the tick after the counter equals compare.
//
// Chosen here: the strobed register port.
module tcoc_top
    import tcoc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              clk_en_i,
    // Register port
    input  wire tcoc_bus_s         bus_i,
    output logic [DATA_W-1:0]      rdata_o,
    // Counter core
    input  wire logic              timer_tick_i,
    input  wire tcoc_cnt_s         cnt_i,
    input  wire logic [CNT_W-1:0]  compare_buf_a_i,
    input  wire logic [CNT_W-1:0]  compare_buf_b_i,
    // Pin side
    output logic                   wave_out_a_o,
    output logic                   wave_out_b_o,
    output logic                   override_a_o,
    output logic                   override_b_o,
    // Status
    output logic [CNT_W-1:0]       compare_value_a_o,
    output logic [CNT_W-1:0]       compare_value_b_o,
    output logic                   compare_match_flag_a_o,
    output logic                   compare_match_flag_b_o,
    output logic                   overflow_flag_o
);

    logic [1:0]       rst_q;
    logic             rst_n;
    logic [1:0]       chan_a_output_mode;
    logic [1:0]       chan_b_output_mode;
    logic [3:0]       waveform_mode;
    logic [1:0]       cmp_flag;
    logic             ovf_flag;
    logic [1:0]       pend_match;
    logic             pend_bottom;
    logic             pend_ovf;
    logic             pend_down;
    logic [1:0]       wave;
    logic [CNT_W-1:0] cmp_q [2];
    logic [DATA_W-1:0] rdata;

    // Reset release through two flops; frozen with the enable, so a
    // held-off block stays in reset until its clock is enabled again
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_q <= 2'h0;
        else if (clk_en_i)
            rst_q <= {rst_q[0], 1'b1};
    end
    assign rst_n = rst_q[1];

    // Mode decode and shared counter landmarks
    tcoc_class_e cls;
    wire         tick      = clk_en_i & timer_tick_i;                     // R1
    wire         at_bottom = (cnt_i.value == CNT_BOTTOM);
    wire         at_top    = (cnt_i.value == cnt_i.top);
    wire         at_max    = (cnt_i.value == CNT_MAX);
    wire         fast_tog  = (waveform_mode == WGM_FAST_TOG_LO) |
                             (waveform_mode == WGM_FAST_TOG_HI);           // R10
    wire         dual_tog  = (waveform_mode == WGM_DUAL_TOG_LO) |
                             (waveform_mode == WGM_DUAL_TOG_HI);           // R14
    assign cls = tcoc_class(waveform_mode);                               // R17

    // Overflow position per class
    logic ovf_pos;
    always_comb
    begin
        case (cls)
            CLS_FAST:           ovf_pos = at_top;
            CLS_PHASE, CLS_PFC: ovf_pos = at_bottom;                      // R3
            default:            ovf_pos = at_max;
        endcase
    end

    // Compare load point per class
    // Non-PWM loads at once; buffered modes wait for their landmark
    // so that one period never mixes an old and a new compare value
    logic load_now;
    always_comb
    begin
        case (cls)
            CLS_PFC, CLS_FAST: load_now = tick & at_bottom;               // R2
            CLS_PHASE:         load_now = tick & at_top;
            default:           load_now = clk_en_i;
        endcase
    end

    // Register decode
    wire wr_a    = bus_i.we & (bus_i.addr == ADDR_CTRL_A);
    wire wr_b    = bus_i.we & (bus_i.addr == ADDR_CTRL_B);
    wire wr_stat = bus_i.we & (bus_i.addr == ADDR_STATUS);
    wire [DATA_W-1:0] ctrl_a_rd = {chan_a_output_mode, chan_b_output_mode,
                                   2'h0, waveform_mode[1:0]};
    wire [DATA_W-1:0] ctrl_b_rd = {3'h0, waveform_mode[3:2], 3'h0};
    wire [DATA_W-1:0] stat_rd   = {5'h00, ovf_flag, cmp_flag};
    wire [DATA_W-1:0] next_rdata =
        !bus_i.re                     ? 8'h00 :
        (bus_i.addr == ADDR_CTRL_A)   ? ctrl_a_rd :
        (bus_i.addr == ADDR_CTRL_B)   ? ctrl_b_rd :
        (bus_i.addr == ADDR_STATUS)   ? stat_rd : 8'h00;

    // Control registers
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chan_a_output_mode <= CTRL_A_RST[CTRL_A_MODE_A_LSB +: 2];
            chan_b_output_mode <= CTRL_A_RST[CTRL_A_MODE_B_LSB +: 2];
            waveform_mode      <= {CTRL_B_RST[CTRL_B_WGM_HI_LSB +: 2],
                                   CTRL_A_RST[CTRL_A_WGM_LO_LSB +: 2]};
        end
        else if (clk_en_i)
        begin
            if (wr_a)
            begin
                chan_a_output_mode <= bus_i.wdata[CTRL_A_MODE_A_LSB +: 2];
                chan_b_output_mode <= bus_i.wdata[CTRL_A_MODE_B_LSB +: 2];
                waveform_mode[1:0] <= bus_i.wdata[CTRL_A_WGM_LO_LSB +: 2]; // R18
            end
            if (wr_b)
                waveform_mode[3:2] <= bus_i.wdata[CTRL_B_WGM_HI_LSB +: 2]; // R18
        end
    end

    // Read data, valid the cycle after the strobe only
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= 8'h00;
        else if (clk_en_i)
            rdata <= next_rdata;
    end
    assign rdata_o = rdata;

    // Landmarks seen at one tick act on the next
    // Acting one tick late keeps flags and pins in step with the
    // counter value that caused them
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend_bottom <= 1'b0;
            pend_ovf    <= 1'b0;
            pend_down   <= 1'b0;
        end
        else if (tick)
        begin
            pend_bottom <= at_bottom;
            pend_ovf    <= ovf_pos;                                       // R3
            pend_down   <= cnt_i.down;
        end
    end

    // Overflow flag, write one to clear, set wins
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            ovf_flag <= 1'b0;
        else if (clk_en_i)
            ovf_flag <= (tick & pend_ovf) |
                        (ovf_flag & ~(wr_stat & bus_i.wdata[STAT_OVF_BIT]));
    end

    // Per-channel compare, flag and waveform logic
    // Channel B never toggles in PWM modes, so tog_ok is tied to channel A
    for (genvar g = 0; g < 2; g++)
    begin : g_chan
        wire [1:0]       com     = (g == 0) ? chan_a_output_mode : chan_b_output_mode;
        wire [CNT_W-1:0] buf_v   = (g == 0) ? compare_buf_a_i : compare_buf_b_i;
        wire             tog_ok  = (g == 0) &&
                                   ((cls == CLS_FAST) ? fast_tog : dual_tog);
        wire             cmp_bot = (cmp_q[g] == CNT_BOTTOM);
        wire             cmp_top = (cmp_q[g] == cnt_i.top);
        wire             clr_bit = wr_stat & bus_i.wdata[STAT_CMP_A_BIT + g];
        logic            next_wave;

        // Waveform action for the class and field
        always_comb
        begin
            next_wave = wave[g];
            case (cls)
                CLS_NONPWM:
                begin
                    if (pend_match[g])
                    begin
                        case (com)
                            COM_TOGGLE: next_wave = ~wave[g];             // R7
                            COM_CLEAR:  next_wave = 1'b0;                 // R8
                            COM_SET:    next_wave = 1'b1;                 // R9
                            default:    next_wave = wave[g];              // R6
                        endcase
                    end
                end
                CLS_FAST:
                begin
                    if (com == COM_TOGGLE)
                    begin
                        if (tog_ok && pend_match[g])
                            next_wave = ~wave[g];                         // R10
                    end
                    else if (com[1])
                    begin
                        if (pend_bottom)
                            next_wave = ~com[0];                          // R11 R12
                        if (pend_match[g] && !cmp_top)
                            next_wave = com[0];                           // R11 R12 R13
                    end
                end
                CLS_PHASE, CLS_PFC:
                begin
                    if (com == COM_TOGGLE)
                    begin
                        if (tog_ok && pend_match[g])
                            next_wave = ~wave[g];                         // R14
                    end
                    else if (com[1])
                    begin
                        if (cmp_bot)
                            next_wave = com[0];                           // R19
                        else if (cmp_top)
                            next_wave = ~com[0];                          // R19
                        else if (pend_match[g])
                            next_wave = pend_down ? ~com[0] : com[0];     // R15 R16
                    end
                end
                default:
                    next_wave = wave[g];
            endcase
        end

        // Active compare value loaded from the buffer
        always_ff @(posedge clk_i or negedge rst_n)
        begin
            if (!rst_n)
                cmp_q[g] <= CMP_RST;
            else if (load_now)
                cmp_q[g] <= buf_v;                                        // R2
        end

        // Match pipeline, flag and output latch
        // A clear written in the same cycle as a set loses
        always_ff @(posedge clk_i or negedge rst_n)
        begin
            if (!rst_n)
            begin
                pend_match[g] <= 1'b0;
                cmp_flag[g]   <= 1'b0;
                wave[g]       <= 1'b0;
            end
            else if (clk_en_i)
            begin
                if (tick)
                    pend_match[g] <= (cnt_i.value == cmp_q[g]);
                cmp_flag[g] <= (tick & pend_match[g]) |
                               (cmp_flag[g] & ~clr_bit);                 // R20
                if (tick && com != COM_OFF)
                    wave[g] <= next_wave;                                 // R1
            end
        end
    end

    // Pin outputs; pin direction is left to the port logic
    // The override alone does not drive the pad: the direction bit
    // in the port logic must select output as well
    assign override_a_o = |chan_a_output_mode;                            // R4 R6
    assign override_b_o = |chan_b_output_mode;                            // R4 R6
    assign wave_out_a_o = wave[0];
    assign wave_out_b_o = wave[1];

    // Status outputs
    assign compare_value_a_o      = cmp_q[0];
    assign compare_value_b_o      = cmp_q[1];
    assign compare_match_flag_a_o = cmp_flag[0];
    assign compare_match_flag_b_o = cmp_flag[1];
    assign overflow_flag_o        = ovf_flag;

endmodule // tcoc_top

// ==== tcoc_top_monitor.sv ====
// Port checker for the timer compare output control block
module tcoc_top_monitor
    import tcoc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              clk_en_i,
    // Inputs watched
    input  wire tcoc_bus_s         bus_i,
    input  wire logic              timer_tick_i,
    // Outputs watched
    input  wire logic [DATA_W-1:0] rdata_o,
    input  wire logic              wave_out_a_o,
    input  wire logic              wave_out_b_o,
    input  wire logic              override_a_o,
    input  wire logic              override_b_o,
    input  wire logic              compare_match_flag_a_o,
    input  wire logic              compare_match_flag_b_o,
    input  wire logic              overflow_flag_o
);
    // Requests taken at this edge
    wire logic       tick_en  = clk_en_i && timer_tick_i;
    wire logic       wr_ctl_a = clk_en_i && bus_i.we && (bus_i.addr == ADDR_CTRL_A);
    wire logic       wr_stat  = clk_en_i && bus_i.we && (bus_i.addr == ADDR_STATUS);
    wire logic       rd_take  = clk_en_i && bus_i.re;
    wire logic       rd_stat  = rd_take && (bus_i.addr == ADDR_STATUS);
    wire logic       rd_unmap = rd_take && (bus_i.addr != ADDR_CTRL_A)
                                && (bus_i.addr != ADDR_CTRL_B) && !rd_stat;
    wire logic [2:0] flags    = {overflow_flag_o, compare_match_flag_b_o, compare_match_flag_a_o};
    wire logic [1:0] waves    = {wave_out_a_o, wave_out_b_o};

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // Pin override follows the written field, and only a write moves it
    a_override_follow: assert property (wr_ctl_a |=> (override_a_o == (|$past(bus_i.wdata[7:6])))
        && (override_b_o == (|$past(bus_i.wdata[5:4])))) else $error("override mismatch");
    a_override_hold: assert property (!wr_ctl_a |=> $stable({override_a_o, override_b_o}))
        else $error("override moved without write");
    // Read data stands one cycle only, unmapped reads zero
    a_rdata_idle: assert property (clk_en_i && !bus_i.re |=> rdata_o == 8'h00)
        else $error("stray read data");
    a_unmapped_read: assert property (rd_unmap |=> rdata_o == 8'h00) else $error("unmapped read");
    a_status_read: assert property (rd_stat |=> rdata_o[2:0] == $past(flags))
        else $error("status read mismatch");
    // Waves move only on a timer tick, wave A never while disconnected
    a_wave_on_tick: assert property (!tick_en |=> $stable(waves)) else $error("wave off tick");
    a_off_no_wave: assert property (!override_a_o |=> $stable(wave_out_a_o))
        else $error("disconnected wave moved");
    // Compare flag: set only after a tick, sticky, write one clears
    a_flag_after_tick: assert property ($rose(compare_match_flag_a_o) |-> $past(tick_en))
        else $error("flag rose without tick");
    a_flag_sticky: assert property (compare_match_flag_a_o && !(wr_stat && bus_i.wdata[0])
        |=> compare_match_flag_a_o) else $error("flag lost");
    a_flag_clear: assert property (wr_stat && bus_i.wdata[0] && !timer_tick_i
        |=> !compare_match_flag_a_o) else $error("flag not cleared");
endmodule // tcoc_top_monitor

bind tcoc_top tcoc_top_monitor i_mon (.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .bus_i(bus_i), .timer_tick_i(timer_tick_i), .rdata_o(rdata_o), .wave_out_a_o(wave_out_a_o),
    .wave_out_b_o(wave_out_b_o), .override_a_o(override_a_o), .override_b_o(override_b_o),
    .compare_match_flag_a_o(compare_match_flag_a_o),
    .compare_match_flag_b_o(compare_match_flag_b_o), .overflow_flag_o(overflow_flag_o));

// ==== tb_tcoc_top.sv ====
// Self-checking testbench for the timer compare output control block
module tb_tcoc_top
    import tcoc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk_i = 1'b0;
    logic              rst_n_i = 1'b0;
    tcoc_bus_s         bus = '0;
    tcoc_cnt_s         cnt = '0;
    logic              tick = 1'b0;
    logic              en = 1'b1;
    logic [CNT_W-1:0]  buf_a = '0;
    logic [CNT_W-1:0]  buf_b = '0;
    logic [CNT_W-1:0]  top_v = 16'h0064;
    logic [DATA_W-1:0] rdata;
    logic              wa, wb, ova, ovb, fa, fb, fo;
    logic [CNT_W-1:0]  cva, cvb;
    int                fails = 0;
    int                n_checks = 0;

    // Device under test
    tcoc_top i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(en), .bus_i(bus),
        .rdata_o(rdata), .timer_tick_i(tick), .cnt_i(cnt), .compare_buf_a_i(buf_a),
        .compare_buf_b_i(buf_b), .wave_out_a_o(wa), .wave_out_b_o(wb), .override_a_o(ova),
        .override_b_o(ovb), .compare_value_a_o(cva), .compare_value_b_o(cvb),
        .compare_match_flag_a_o(fa), .compare_match_flag_b_o(fb), .overflow_flag_o(fo));

    // Compare, count, report
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic cw(input logic ea, input logic eb);
        check(16'({wa, wb}), 16'({ea, eb}));
    endtask
    // One-cycle bus write and read, read data in the following cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clk_i);
        bus <= '0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge clk_i);
        bus <= '0;
        #1;
        check(16'(rdata), 16'(exp));
    endtask
    // One timer tick with the given counter value and direction
    task automatic tk(input logic [15:0] v, input logic dn);
        @(posedge clk_i);
        tick <= 1'b1;
        cnt <= '{value: v, top: top_v, down: dn};
        @(posedge clk_i);
        tick <= 1'b0;
        #1;
    endtask
    task automatic setb(input logic [15:0] a, input logic [15:0] b);
        @(posedge clk_i);
        buf_a <= a;
        buf_b <= b;
    endtask

    task automatic t_regs();
        rd(ADDR_CTRL_A, CTRL_A_RST);
        rd(ADDR_STATUS, 8'h00);
        check(16'({ova, ovb, wa, wb}), 16'h0000);
        wr(ADDR_CTRL_A, 8'hFF);
        rd(ADDR_CTRL_A, 8'hF3);
        check(16'({ova, ovb}), 16'h0003);
        wr(ADDR_CTRL_B, 8'hFF);
        rd(ADDR_CTRL_B, 8'h18);
        rd(8'h90, 8'h00);
        wr(ADDR_CTRL_A, 8'h40);
        check(16'({ova, ovb}), 16'h0002);
        wr(ADDR_CTRL_A, 8'h10);
        check(16'({ova, ovb}), 16'h0001);
        wr(ADDR_CTRL_B, 8'h00);
        $display("test registers done");
    endtask

    task automatic t_nonpwm();
        logic [1:0] ma [5] = '{2'h3, 2'h1, 2'h1, 2'h0, 2'h2};
        logic [1:0] mb [5] = '{2'h1, 2'h0, 2'h3, 2'h2, 2'h1};
        logic       ea [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
        logic       eb [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
        setb(16'h0005, 16'h0005);
        for (int i = 0; i < 5; i++)
        begin
            wr(ADDR_CTRL_A, {ma[i], mb[i], 4'h0});
            tk(16'h0005, 1'b0);
            check(16'(fa), 16'h0000);
            tk(16'h0006, 1'b0);
            check(16'({fa, fb}), 16'h0003);
            cw(ea[i], eb[i]);
            check(cva, 16'h0005);
            wr(ADDR_STATUS, 8'h07);
        end
        tk(16'hFFFF, 1'b0);
        check(16'(fo), 16'h0000);
        tk(16'h0000, 1'b0);
        rd(ADDR_STATUS, 8'h04);
        wr(ADDR_STATUS, 8'h04);
        check(16'(fo), 16'h0000);
        $display("test non-pwm done");
    endtask

    task automatic t_fast();
        setb(16'h0014, 16'h0032);
        wr(ADDR_CTRL_B, 8'h18);
        wr(ADDR_CTRL_A, 8'hB2);
        tk(16'h0000, 1'b0);
        tk(16'h0001, 1'b0);
        cw(1'b1, 1'b0);
        tk(16'h0014, 1'b0);
        tk(16'h0015, 1'b0);
        cw(1'b0, 1'b0);
        tk(16'h0032, 1'b0);
        tk(16'h0033, 1'b0);
        cw(1'b0, 1'b1);
        setb(16'h0014, 16'h0064);
        tk(16'h0064, 1'b0);
        check(cvb, 16'h0032);
        tk(16'h0000, 1'b0);
        tk(16'h0001, 1'b0);
        cw(1'b1, 1'b0);
        tk(16'h0064, 1'b0);
        tk(16'h0000, 1'b0);
        cw(1'b1, 1'b0);
        wr(ADDR_CTRL_A, 8'h52);
        tk(16'h0014, 1'b0);
        tk(16'h0064, 1'b0);
        cw(1'b0, 1'b0);
        wr(ADDR_CTRL_B, 8'h08);
        wr(ADDR_CTRL_A, 8'h51);
        tk(16'h0014, 1'b0);
        tk(16'h0015, 1'b0);
        cw(1'b0, 1'b0);
        $display("test fast pwm done");
    endtask

    task automatic t_dual();
        setb(16'h0028, 16'h0028);
        wr(ADDR_CTRL_B, 8'h10);
        wr(ADDR_CTRL_A, 8'hB1);
        tk(16'h0000, 1'b0);
        tk(16'h0001, 1'b0);
        check(cva, 16'h0028);
        tk(16'h0028, 1'b0);
        tk(16'h0029, 1'b0);
        cw(1'b0, 1'b1);
        setb(16'h003C, 16'h0028);
        tk(16'h0064, 1'b1);
        tk(16'h0063, 1'b1);
        check(cva, 16'h0028);
        tk(16'h0028, 1'b1);
        tk(16'h0027, 1'b1);
        cw(1'b1, 1'b0);
        tk(16'h0000, 1'b1);
        tk(16'h0001, 1'b0);
        check(cva, 16'h003C);
        wr(ADDR_CTRL_A, 8'h51);
        tk(16'h003C, 1'b0);
        tk(16'h003D, 1'b0);
        cw(1'b0, 1'b0);
        wr(ADDR_CTRL_A, 8'hE1);
        setb(16'h0000, 16'h0064);
        tk(16'h0000, 1'b1);
        tk(16'h0005, 1'b0);
        cw(1'b1, 1'b1);
        $display("test dual-slope done");
    endtask

    // Enable low freezes registers and flags
    task automatic t_enable();
        @(posedge clk_i);
        en <= 1'b0;
        wr(ADDR_STATUS, 8'h07);
        wr(ADDR_CTRL_A, 8'h00);
        check(16'({fo, ova, ovb}), 16'h0007);
        @(posedge clk_i);
        en <= 1'b1;
        wr(ADDR_CTRL_A, 8'h00);
        check(16'({ova, ovb}), 16'h0000);
        $display("test clock enable done");
    endtask

    // Counts, verdict, end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always #4 clk_i = ~clk_i;

    // Reset, then the scenarios
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        t_regs();
        t_nonpwm();
        t_fast();
        t_dual();
        t_enable();
        print_verdict();
    end

    // Watchdog against a hang
    initial
    begin
        #100us;
        fails++;
        print_verdict();
    end
endmodule // tb_tcoc_top
